// >>> emb_xmem_consts.vh
// constants for the external data memory bus controller
// assumes inclusion by bare name from the design files
`ifndef EMB_XMEM_CONSTS_VH
`define EMB_XMEM_CONSTS_VH

// register indices (word address on the bus)
`define EMB_IDX_MEM_IF_CTRL   8'h8E
`define EMB_IDX_UPPER_PORT    8'hA0
`define EMB_IDX_PORT0_CFG     8'hB0
`define EMB_IDX_LATCH_GPIO    8'hC0
`define EMB_IDX_STATUS        8'hF0

// memory_interface_control field positions
`define EMB_BIT_LATCH_POL     0
`define EMB_BIT_EXT_RAM_EN    1
`define EMB_BIT_WS_LO         2
`define EMB_BIT_WS_HI         3
`define EMB_BIT_EXT_STACK_EN  4

// port0 configuration field positions
`define EMB_BIT_P0_IDLE_DRIVE 8

// reset values
`define EMB_RST_MEM_IF_CTRL   5'h00
`define EMB_RST_UPPER_PORT    8'hFF
`define EMB_RST_P0_IDLE_VAL   8'hFF
`define EMB_RST_LATCH_GPIO    1'h1

// top of the internally mapped data space
`define EMB_INT_TOP           16'h0FFF

// edges from strobe end until the synchronised read byte is taken
`define EMB_RD_TAIL_CYCLES    3'h4

`endif

// >>> emb_sync3.v
// three-stage input synchroniser with agreement filter
// assumes din comes from pins outside the core_clk domain
`timescale 1ns/1ns
module emb_sync3 #(
    parameter WIDTH = 8
) (
    input  wire             core_clk,
    input  wire             rst_b,
    input  wire [WIDTH-1:0] din,
    output reg  [WIDTH-1:0] dout
);
    reg [WIDTH-1:0] s1_q;
    reg [WIDTH-1:0] s2_q;
    reg [WIDTH-1:0] s3_q;

    // ==================================================
    // stage chain; only s2 reads s1
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s1_q <= {WIDTH{1'b0}};
            s2_q <= {WIDTH{1'b0}};
            s3_q <= {WIDTH{1'b0}};
            dout <= {WIDTH{1'b0}};
        end
        else
        begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
                dout <= s3_q;  // change counts once two stages agree
        end
    end
endmodule

// >>> emb_strobe_timer.v
// strobe width counter: counts wait_states+1 cycles, flags the last one
// assumes load is pulsed once, the cycle before the strobe starts
`timescale 1ns/1ns
`include "emb_xmem_consts.vh"
module emb_strobe_timer (
    input  wire       core_clk,
    input  wire       rst_b,
    input  wire       load,
    input  wire [1:0] wait_states,
    output wire       last
);
    reg [1:0] cnt_q;

    // ==================================================
    // down counter; zero marks the final strobe cycle
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            cnt_q <= 2'h0;
        else if (load)
            cnt_q <= wait_states;
        else if (cnt_q != 2'h0)
            cnt_q <= cnt_q - 2'h1;
    end

    assign last = (cnt_q == 2'h0);
endmodule

// >>> emb_xmem_bus.v
// external data memory bus controller with avalon-mm register slave
// assumes core request port on core_clk, pins resolved by the bench
// What this block does
// - upper address on upper port; low address and data share the multiplexed port.
// - pointer-based moves present a full 16-bit address, reaching 64K bytes.
// - latch pulse captures low address; upper port held through whole access.
// - index-based moves output only an 8-bit address within a 256-byte block.
// - paged mode leaves upper port at the software-written page value.
// - wait-state code 0..3 makes strobes last 1..4 clock periods.
// - external RAM enable low sends internal addresses inside, no bus cycle.
// - external RAM enable high routes every address to the external bus.
// - polarity bit parks latch at the latch gpio value when 0, low when 1; pulse active high.
// - latch pulses only during external accesses, idle level otherwise.
// - latch pin works as general I/O only while polarity bit is zero.
// - multiplexed port drives address and write data, tristates for read data.
// - without an access the multiplexed port returns to its configured idle.
// - address stable on both ports when the latch pulse falls.
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`include "emb_xmem_consts.vh"
module emb_xmem_bus (
    input  wire        core_clk,
    input  wire        rst_b,
    // avalon-mm register slave
    input  wire [7:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    // core data move requests
    input  wire        req_valid,
    input  wire        req_write,
    input  wire        req_paged,
    input  wire [15:0] req_addr,
    input  wire [7:0]  req_wdata,
    output reg         req_ready,
    output reg         rsp_valid,
    output reg  [7:0]  rsp_rdata,
    // internal data memory
    output reg         int_req,
    output reg         int_we,
    output reg  [15:0] int_addr,
    output reg  [7:0]  int_wdata,
    input  wire [7:0]  int_rdata,
    // pins
    output reg  [7:0]  upper_address_port,
    output reg  [7:0]  mux_port_out,
    output reg         mux_port_oe_n,
    input  wire [7:0]  mux_port_in,
    output reg         addr_latch,
    output reg         rd_strobe_n,
    output reg         wr_strobe_n
);
    // ==================================================
    // access flow: address -> latch fall -> strobe -> tail for reads
    // the address phase drives both ports; the latch falls one cycle later
    // the strobe timer is armed one cycle ahead, so the first strobe
    // cycle already sees the programmed count
    // fsm states, one-hot
    localparam S_IDLE  = 6'b000001;
    localparam S_INT   = 6'b000010;
    localparam S_ADDR  = 6'b000100;
    localparam S_LATCH = 6'b001000;
    localparam S_STRB  = 6'b010000;
    localparam S_TAIL  = 6'b100000;

    // control, page and port config registers, then per-access state
    reg  [5:0]  state_q;
    reg  [4:0]  ctrl_q;
    reg  [7:0]  page_q;
    reg  [7:0]  p0_idle_q;
    reg         p0_idle_drv_q;
    reg         gpio_q;
    reg         op_write_q;
    reg  [7:0]  op_wdata_q;
    reg  [2:0]  tail_q;
    reg         strb_load;
    wire        strb_last;
    wire [7:0]  mux_in_sync;
    wire [1:0]  wait_states;
    wire        latch_pol;
    wire        ext_ram_en;
    wire [15:0] eff_addr;
    wire        go_internal;
    wire        bus_acc;
    reg  [31:0] rd_mux;

    assign latch_pol   = ctrl_q[`EMB_BIT_LATCH_POL];
    assign ext_ram_en  = ctrl_q[`EMB_BIT_EXT_RAM_EN];
    assign wait_states = ctrl_q[`EMB_BIT_WS_HI:`EMB_BIT_WS_LO];
    // paged moves decode with the page register on top
    // so a low page with the external enable clear never reaches the pins
    assign eff_addr    = req_paged ? {page_q, req_addr[7:0]} : req_addr;
    assign go_internal = !ext_ram_en && (eff_addr <= `EMB_INT_TOP);
    assign bus_acc     = avs_waitrequest && (avs_read || avs_write);

    // ==================================================
    // helpers: pin synchroniser and strobe width counter
    // the port input is asynchronous to core_clk, hence the three stages
    emb_sync3 #(
        .WIDTH (8)
    ) u_sync (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .din      (mux_port_in),
        .dout     (mux_in_sync)
    );

    emb_strobe_timer u_strobe (
        .core_clk    (core_clk),
        .rst_b       (rst_b),
        .load        (strb_load),
        .wait_states (wait_states),
        .last        (strb_last)
    );

    // ==================================================
    // register bus: one wait cycle, then answer
    // word indices: control 8E, page A0, port0 idle B0, latch gpio C0,
    // status F0; unmapped indices read zero and ignore writes
    // only byte lane 0 is looked at, except lane 1 for the idle drive bit
    always @*
    begin
        rd_mux = 32'h0000_0000;  // unmapped reads as zero
        case (avs_address)
            `EMB_IDX_MEM_IF_CTRL: rd_mux = {27'h0, ctrl_q};
            `EMB_IDX_UPPER_PORT:  rd_mux = {24'h0, page_q};
            `EMB_IDX_PORT0_CFG:   rd_mux = {23'h0, p0_idle_drv_q, p0_idle_q};
            `EMB_IDX_LATCH_GPIO:  rd_mux = {31'h0, gpio_q};
            `EMB_IDX_STATUS:      rd_mux = {16'h0, rsp_rdata, 7'h0, !state_q[0]};
            default:              rd_mux = 32'h0000_0000;
        endcase
    end

    // register file and handshake; readdata captured in the wait cycle
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
            ctrl_q          <= `EMB_RST_MEM_IF_CTRL;
            page_q          <= `EMB_RST_UPPER_PORT;
            p0_idle_q       <= `EMB_RST_P0_IDLE_VAL;
            p0_idle_drv_q   <= 1'b0;
            gpio_q          <= `EMB_RST_LATCH_GPIO;
        end
        else
        begin
            avs_waitrequest <= !bus_acc;
            if (bus_acc && avs_read)
                avs_readdata <= rd_mux;
            // write lands at the edge where waitrequest is seen low
            if (avs_write && !avs_waitrequest && avs_byteenable[0])
            begin
                case (avs_address)
                    `EMB_IDX_MEM_IF_CTRL: ctrl_q    <= avs_writedata[4:0];
                    `EMB_IDX_UPPER_PORT:  page_q    <= avs_writedata[7:0];
                    `EMB_IDX_PORT0_CFG:   p0_idle_q <= avs_writedata[7:0];
                    `EMB_IDX_LATCH_GPIO:  gpio_q    <= avs_writedata[0];
                    default:              ;
                endcase
            end
            if (avs_write && !avs_waitrequest && avs_byteenable[1] &&
                avs_address == `EMB_IDX_PORT0_CFG)
                p0_idle_drv_q <= avs_writedata[`EMB_BIT_P0_IDLE_DRIVE];
        end
    end

    // ==================================================
    // access sequencer; all pins registered
    // costs a cycle of latency per phase but keeps the strobes glitch free
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q            <= S_IDLE;
            req_ready          <= 1'b1;
            rsp_valid          <= 1'b0;
            rsp_rdata          <= 8'h00;
            int_req            <= 1'b0;
            int_we             <= 1'b0;
            int_addr           <= 16'h0000;
            int_wdata          <= 8'h00;
            upper_address_port <= `EMB_RST_UPPER_PORT;
            mux_port_out       <= `EMB_RST_P0_IDLE_VAL;
            mux_port_oe_n      <= 1'b1;
            addr_latch         <= 1'b1;
            rd_strobe_n        <= 1'b1;
            wr_strobe_n        <= 1'b1;
            op_write_q         <= 1'b0;
            op_wdata_q         <= 8'h00;
            tail_q             <= 3'h0;
            strb_load          <= 1'b0;
        end
        else
        begin
            rsp_valid <= 1'b0;
            int_req   <= 1'b0;
            strb_load <= 1'b0;
            case (state_q)
                S_IDLE:
                begin
                    // idle: port config drives mux port, latch parked
                    mux_port_out       <= p0_idle_q;
                    mux_port_oe_n      <= !p0_idle_drv_q;
                    addr_latch         <= latch_pol ? 1'b0 : gpio_q;
                    upper_address_port <= page_q;
                    if (req_valid)
                    begin
                        req_ready  <= 1'b0;
                        op_write_q <= req_write;
                        op_wdata_q <= req_wdata;
                        if (go_internal)
                        begin
                            // internal hit: no bus cycle at all
                            int_req   <= 1'b1;
                            int_we    <= req_write;
                            int_addr  <= eff_addr;
                            int_wdata <= req_wdata;
                            state_q   <= S_INT;
                        end
                        else
                        begin
                            addr_latch    <= 1'b1;
                            mux_port_out  <= req_addr[7:0];
                            mux_port_oe_n <= 1'b0;
                            if (!req_paged)
                                upper_address_port <= req_addr[15:8];
                            state_q <= S_ADDR;
                        end
                    end
                end
                S_INT:
                begin
                    rsp_valid <= 1'b1;
                    rsp_rdata <= op_write_q ? rsp_rdata : int_rdata;
                    req_ready <= 1'b1;
                    state_q   <= S_IDLE;
                end
                S_ADDR:
                begin
                    // latch falls while address still stands on both ports
                    addr_latch <= 1'b0;
                    // arm the width counter so it holds the count in the first strobe cycle
                    strb_load  <= 1'b1;
                    state_q    <= S_LATCH;
                end
                S_LATCH:
                begin
                    if (op_write_q)
                    begin
                        mux_port_out <= op_wdata_q;
                        wr_strobe_n  <= 1'b0;
                    end
                    else
                    begin
                        mux_port_oe_n <= 1'b1;
                        rd_strobe_n   <= 1'b0;
                    end
                    state_q <= S_STRB;
                end
                S_STRB:
                begin
                    // strobe lasts wait_states+1 cycles
                    if (strb_last && !strb_load)
                    begin
                        wr_strobe_n <= 1'b1;
                        rd_strobe_n <= 1'b1;
                        tail_q      <= `EMB_RD_TAIL_CYCLES;
                        if (op_write_q)
                        begin
                            rsp_valid <= 1'b1;
                            req_ready <= 1'b1;
                            state_q   <= S_IDLE;
                        end
                        else
                            state_q <= S_TAIL;
                    end
                end
                S_TAIL:
                begin
                    // synchroniser lag: this value is the pin at strobe end
                    // the pin passes three stages plus the agreement register,
                    // so the strobe-end byte shows up four edges later;
                    // the ram must hold it one cycle past the strobe
                    tail_q <= tail_q - 3'h1;
                    if (tail_q == 3'h1)
                    begin
                        rsp_rdata <= mux_in_sync;
                        rsp_valid <= 1'b1;
                        req_ready <= 1'b1;
                        state_q   <= S_IDLE;
                    end
                end
                default:
                    state_q <= S_IDLE;
            endcase
        end
    end
endmodule

// >>> emb_xmem_bus_properties.sv
// concurrent checks on the pins and request port of the external memory bus
// assumes binding to emb_xmem_bus; control fields tracked from register writes
`timescale 1ns/1ns
`include "emb_xmem_consts.vh"
module emb_xmem_bus_properties (
    input wire        core_clk,
    input wire        rst_b,
    input wire [7:0]  avs_address,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire        avs_waitrequest,
    input wire        req_valid,
    input wire        req_paged,
    input wire [15:0] req_addr,
    input wire        req_ready,
    input wire        int_req,
    input wire [15:0] int_addr,
    input wire [7:0]  upper_address_port,
    input wire [7:0]  mux_port_out,
    input wire        mux_port_oe_n,
    input wire        addr_latch,
    input wire        rd_strobe_n,
    input wire        wr_strobe_n
);
    reg        pol_q;
    reg        ext_q;
    reg [1:0]  ws_q;
    reg [2:0]  lo_q;
    reg [15:0] addr_q;
    // ====================================
    // shadow of control fields and strobe length
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pol_q <= 1'b0;
            ext_q <= 1'b0;
            ws_q  <= 2'h0;
            lo_q  <= 3'h0;
        end
        else
        begin
            if (avs_write && !avs_waitrequest && avs_address == `EMB_IDX_MEM_IF_CTRL)
            begin
                pol_q <= avs_writedata[0];
                ext_q <= avs_writedata[1];
                ws_q  <= avs_writedata[3:2];
            end
            lo_q <= (!rd_strobe_n || !wr_strobe_n) ? lo_q + 3'h1 : 3'h0;
        end
    end
    // address of the request just taken
    always @(posedge core_clk)
    begin
        if (req_valid && req_ready)
            addr_q <= req_addr;
    end
    // ====================================
    // assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence s_lin;
        req_valid && req_ready && !req_paged && (ext_q || req_addr > `EMB_INT_TOP);
    endsequence
    sequence s_pg;
        req_valid && req_ready && req_paged && ext_q;
    endsequence
    sequence s_addr_phase;
        addr_latch && !mux_port_oe_n && mux_port_out == addr_q[7:0];
    endsequence
    a_linear_addr: assert property (s_lin |=> s_addr_phase ##0 upper_address_port == addr_q[15:8])
        else $error("linear address phase wrong");
    a_paged_addr: assert property (s_pg |=> s_addr_phase ##0 $stable(upper_address_port))
        else $error("paged address phase wrong");
    a_upper_hold: assert property (!req_ready && !$past(req_ready) |-> $stable(upper_address_port))
        else $error("upper port moved during access");
    a_latch_fall: assert property ($fell(addr_latch) && !req_ready |-> $stable(mux_port_out) && !mux_port_oe_n)
        else $error("address unstable at latch fall");
    a_read_float: assert property (!rd_strobe_n |-> mux_port_oe_n && wr_strobe_n)
        else $error("port driven during read strobe");
    a_write_drive: assert property (!wr_strobe_n |-> !mux_port_oe_n)
        else $error("port not driven during write strobe");
    a_wdata_hold: assert property (!wr_strobe_n && !$past(wr_strobe_n) |-> $stable(mux_port_out))
        else $error("write data changed in strobe");
    a_strobe_width: assert property ($rose(rd_strobe_n) || $rose(wr_strobe_n) |-> lo_q == {1'b0, ws_q} + 3'h1)
        else $error("strobe width wrong");
    a_int_quiet: assert property (int_req |-> !ext_q && int_addr <= `EMB_INT_TOP && rd_strobe_n && wr_strobe_n)
        else $error("internal access misrouted");
    a_idle_low: assert property (pol_q && $past(pol_q) && req_ready && $past(req_ready) |-> !addr_latch)
        else $error("latch not parked low");
endmodule

bind emb_xmem_bus emb_xmem_bus_properties u_props (.core_clk, .rst_b, .avs_address, .avs_write, .avs_writedata,
    .avs_waitrequest, .req_valid, .req_paged, .req_addr, .req_ready, .int_req, .int_addr, .upper_address_port,
    .mux_port_out, .mux_port_oe_n, .addr_latch, .rd_strobe_n, .wr_strobe_n);

// >>> emb_xram_model.sv
// external ram with address latch register on the multiplexed port
// assumes pins straight from emb_xmem_bus; resolves the shared port level
`timescale 1ns/1ns
module emb_xram_model (
    input  wire       core_clk,
    input  wire       late,
    input  wire       addr_latch,
    input  wire       rd_strobe_n,
    input  wire       wr_strobe_n,
    input  wire [7:0] upper_address_port,
    input  wire [7:0] mux_port_out,
    input  wire       mux_port_oe_n,
    output wire [7:0] mux_port_in
);
    reg  [7:0] mem [0:65535];
    reg  [7:0] lo_q;
    reg  [7:0] last_q;
    reg        rd_q;
    wire [15:0] addr = {upper_address_port, lo_q};
    // ====================================
    // late mode: data valid only from the second strobe cycle on
    assign mux_port_in = !mux_port_oe_n ? mux_port_out :
                         ((!rd_strobe_n || rd_q) && (!late || rd_q)) ? mem[addr] : ~last_q;
    // low byte captured as the latch pulse falls
    always @(negedge addr_latch)
        lo_q <= mux_port_out;
    // write lands at the end of the strobe
    always @(posedge wr_strobe_n)
        mem[addr] <= mux_port_in;
    // read hold of one cycle; released line keeps toggling
    always @(posedge core_clk)
    begin
        rd_q   <= !rd_strobe_n;
        last_q <= mux_port_in;
    end
endmodule

// >>> test_emb_xmem_bus.sv
// self-checking bench for the external data memory bus controller
// assumes emb_xmem_bus, emb_xram_model and the bound checker are compiled
`timescale 1ns/1ns
`include "emb_xmem_consts.vh"
module test_emb_xmem_bus;
    reg         core_clk = 1'b0;
    reg         rst_b = 1'b0;
    reg         avs_read = 1'b0;
    reg         avs_write = 1'b0;
    reg  [7:0]  avs_address = 8'h00;
    reg  [31:0] avs_writedata = 32'h0;
    reg         req_valid = 1'b0;
    reg         req_write = 1'b0;
    reg         req_paged = 1'b0;
    reg  [15:0] req_addr = 16'h0;
    reg  [7:0]  req_wdata = 8'h00;
    reg  [7:0]  int_rdata;
    reg         late = 1'b0;
    reg  [7:0]  imem [0:255];
    reg  [31:0] rdv;
    reg  [7:0]  rd_b;
    integer     n_fail = 0;
    integer     checked = 0;
    integer     i;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest, req_ready, rsp_valid, int_req, int_we;
    wire [7:0]  rsp_rdata, int_wdata, upper_address_port, mux_port_out, mux_port_in;
    wire [15:0] int_addr;
    wire        mux_port_oe_n, addr_latch, rd_strobe_n, wr_strobe_n;

    emb_xmem_bus dut (.core_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .req_valid, .req_write, .req_paged,
        .req_addr, .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .int_req, .int_we, .int_addr,
        .int_wdata, .int_rdata, .upper_address_port, .mux_port_out, .mux_port_oe_n, .mux_port_in,
        .addr_latch, .rd_strobe_n, .wr_strobe_n);
    emb_xram_model ram (.core_clk, .late, .addr_latch, .rd_strobe_n, .wr_strobe_n,
        .upper_address_port, .mux_port_out, .mux_port_oe_n, .mux_port_in);

    // ====================================
    // clock and internal memory answering within the request cycle
    initial forever #5 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        if (int_req && int_we)
            imem[int_addr[7:0]] <= int_wdata;
    end
    // the design takes read data in the cycle that int_req stands
    always @*
        int_rdata = imem[int_addr[7:0]];
    // ====================================
    // reporting
    task end_sim;
    begin
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
    endtask
    task chk_val(input [31:0] g, input [31:0] e);
    begin
        checked = checked + 1;
        if (g !== e)
        begin
            n_fail = n_fail + 1;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    end
    endtask
    task chk_lat(input integer g, input integer e);
    begin
        checked = checked + 1;
        if (g != e)
        begin
            n_fail = n_fail + 1;
            $display("MISMATCH t=%0t latency %0d exp %0d", $time, g, e);
        end
    end
    endtask
    // ====================================
    // avalon access: hold until waitrequest low, bounded
    task bus(input w, input [7:0] a, input [31:0] d);
        integer n;
    begin
        avs_address <= a; avs_writedata <= d; avs_write <= w; avs_read <= !w;
        n = 0;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0 && n < 20)
        begin
            n = n + 1;
            @(posedge core_clk);
        end
        rdv = avs_readdata;
        avs_write <= 1'b0; avs_read <= 1'b0;
        if (n >= 20) begin chk_lat(n, 1); end_sim; end
        @(posedge core_clk);
    end
    endtask
    // core move: expected answer lat cycles after the taking edge
    task mv(input w, input p, input [15:0] a, input [7:0] d, input integer lat);
        integer n;
    begin
        req_valid <= 1'b1; req_write <= w; req_paged <= p; req_addr <= a; req_wdata <= d;
        @(posedge core_clk);
        req_valid <= 1'b0;
        n = 0;
        do begin @(posedge core_clk); n = n + 1; end while (rsp_valid !== 1'b1 && n < 20);
        rd_b = rsp_rdata;
        chk_lat(n, lat);
        if (n >= 20) end_sim;
    end
    endtask
    // ====================================
    // scenarios
    task t_regs;
    begin
        bus(0, `EMB_IDX_MEM_IF_CTRL, 0); chk_val(rdv, 32'h00);
        bus(1, `EMB_IDX_MEM_IF_CTRL, 32'h1F);
        bus(0, `EMB_IDX_MEM_IF_CTRL, 0); chk_val(rdv, 32'h1F);
        bus(1, 8'h10, 32'hFF); bus(0, 8'h10, 0); chk_val(rdv, 32'h0);
    end
    endtask
    task t_lin;
    begin
        for (i = 0; i < 4; i = i + 1)
        begin
            bus(1, `EMB_IDX_MEM_IF_CTRL, i << 2);
            late <= (i != 0);
            mv(1, 0, 16'h1000 + i, 8'hC3 ^ i, 4 + i);
            chk_val(ram.mem[16'h1000 + i], 8'hC3 ^ i);
            mv(0, 0, 16'h1000 + i, 8'h00, 8 + i);
            chk_val(rd_b, 8'hC3 ^ i);
        end
        late <= 1'b0;
    end
    endtask
    task t_int;
    begin
        bus(1, `EMB_IDX_MEM_IF_CTRL, 32'h0);
        mv(1, 0, 16'h0FFF, 8'h5A, 2);
        chk_val(imem[8'hFF], 8'h5A);
        mv(0, 0, 16'h0FFF, 8'h00, 2); chk_val(rd_b, 8'h5A);
        bus(1, `EMB_IDX_MEM_IF_CTRL, 32'h2);
        mv(1, 0, 16'h0FFF, 8'hA5, 4);
        chk_val(ram.mem[16'h0FFF], 8'hA5);
        chk_val(imem[8'hFF], 8'h5A);
    end
    endtask
    task t_pg;
    begin
        bus(1, `EMB_IDX_UPPER_PORT, 32'h3C);
        mv(1, 1, 16'hEE55, 8'h77, 4);
        chk_val(ram.mem[16'h3C55], 8'h77);
        chk_val(upper_address_port, 8'h3C);
        mv(0, 1, 16'h0055, 8'h00, 8); chk_val(rd_b, 8'h77);
    end
    endtask
    task t_latch;
    begin
        bus(1, `EMB_IDX_MEM_IF_CTRL, 32'h1);
        mv(1, 0, 16'h2000, 8'h11, 4);
        repeat (2) @(posedge core_clk);
        chk_val(addr_latch, 1'b0);
        bus(1, `EMB_IDX_MEM_IF_CTRL, 32'h0);
        bus(1, `EMB_IDX_LATCH_GPIO, 32'h0);
        repeat (2) @(posedge core_clk);
        chk_val(addr_latch, 1'b0);
        bus(1, `EMB_IDX_LATCH_GPIO, 32'h1);
        repeat (2) @(posedge core_clk);
        chk_val(addr_latch, 1'b1);
    end
    endtask
    task t_idle;
    begin
        bus(1, `EMB_IDX_PORT0_CFG, 32'h1A5);
        bus(1, `EMB_IDX_MEM_IF_CTRL, 32'h2);
        mv(0, 0, 16'h1000, 8'h00, 8);
        repeat (2) @(posedge core_clk);
        chk_val({mux_port_oe_n, mux_port_out}, 9'h0A5);
        bus(1, `EMB_IDX_PORT0_CFG, 32'h0A5);
        repeat (2) @(posedge core_clk);
        chk_val(mux_port_oe_n, 1'b1);
    end
    endtask
    // ====================================
    // main sequence
    initial
    begin
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        t_regs;
        t_lin;
        t_int;
        t_pg;
        t_latch;
        t_idle;
        end_sim;
    end
endmodule
